// ==== fwsp_pkg.sv ====
// package of constants for the flash write-status poll controller
// Functional notes
// - read status byte twice before judging toggle
// - equal toggle reads mean operation finished
// - still toggling: check fail bit, reread twice
// - recheck stopped passes; still toggling fails
// - toggling without fail: poll on, restart later
// - after failure host writes reset command
// - skip window check only if spacing short
// - check window before and after each sector
// - present valid address for status reads
package fwsp_pkg;
  localparam int ADDR_W = 22;             // byte address width
  localparam int DATA_W = 8;              // data bus byte width
  localparam int BIT_COMPLETION = 7;      // completion polarity bit
  localparam int BIT_RUN_TOGGLE = 6;      // run toggle bit
  localparam int BIT_TIMEOUT_FAIL = 5;    // timeout fail bit
  localparam int BIT_ERASE_WINDOW = 3;    // erase window bit
  localparam int BIT_SECTOR_TOGGLE = 2;   // sector toggle bit
  localparam int CLK_MHZ = 25;            // clock rate
  localparam int STROBE_NS = 80;          // least read/write strobe width
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;  // rounded up
  localparam int RESET_ADDR = 0;          // address used for reset command
  localparam logic [7:0] RESET_CMD = 8'hF0;  // reset command byte
  localparam logic [1:0] RES_PASS = 2'h1; // result codes
  localparam logic [1:0] RES_FAIL = 2'h2;
  localparam logic [1:0] RES_RUN = 2'h3;  // still running, poll abandoned
  typedef enum logic [1:0] {FWSP_OP_READ, FWSP_OP_WRITE} fwsp_op_t;
endpackage : fwsp_pkg

// ==== fwsp_bus_cycle.sv ====
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module fwsp_bus_cycle
  import fwsp_pkg::*;
#(
  parameter int STROBE = STROBE_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic [DATA_W-1:0] dq_in,
  output logic done_out,
  output logic [DATA_W-1:0] rdata_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n_out,
  output logic chip_en_n_out,
  output logic out_en_n_out,
  output logic wr_en_n_out
);
  // refuse strobe counts that the eight-bit counter plus sampler margin cannot reach
  if (STROBE < 1 || STROBE > 252) begin : g_bad_strobe
    $error("strobe count out of range");
  end
  typedef enum logic [1:0] {FWSP_C_IDLE, FWSP_C_STROBE, FWSP_C_END} fwsp_cst_t;
  fwsp_cst_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;               // strobe width counter
  logic wr_q, wr_d;                       // cycle is a write
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
  logic [DATA_W-1:0] s1_q, s2_q, s3_q;    // three-stage pin sampler
  logic done_q, done_d;
  // next-state logic; data sampled only once stages two and three agree
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    addr_d = addr_q;
    wd_d = wd_q;
    rd_d = rd_q;
    done_d = 1'b0;
    unique case (st_q)
      FWSP_C_IDLE: begin
        if (start_in) begin
          st_d = FWSP_C_STROBE;
          cnt_d = 8'h00;
          wr_d = write_in;
          addr_d = addr_in;
          wd_d = wdata_in;
        end
      end
      FWSP_C_STROBE: begin
        cnt_d = cnt_q + 8'h01;
        // extra three cycles cover the sampler depth
        if (cnt_q >= 8'(STROBE + 3) && (wr_q || s2_q == s3_q)) begin
          rd_d = s3_q;
          st_d = FWSP_C_END;
        end
      end
      FWSP_C_END: begin
        done_d = 1'b1;
        st_d = FWSP_C_IDLE;
      end
      default: st_d = FWSP_C_IDLE;
    endcase
  end
  // registers; clock enable freezes everything
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= FWSP_C_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      addr_q <= '0;
      wd_q <= '0;
      rd_q <= '0;
      done_q <= 1'b0;
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce_in) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      done_q <= done_d;
      s1_q <= dq_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign done_out = done_q;
  assign rdata_out = rd_q;
  assign addr_out = addr_q;
  assign dq_out = wd_q;
  // drive the bus only during a write strobe (enable active low)
  assign dq_oe_n_out = !(st_q == FWSP_C_STROBE && wr_q);
  assign chip_en_n_out = !(st_q == FWSP_C_STROBE);
  assign out_en_n_out = !(st_q == FWSP_C_STROBE && !wr_q);
  assign wr_en_n_out = !(st_q == FWSP_C_STROBE && wr_q);
endmodule : fwsp_bus_cycle
`default_nettype wire

// ==== fwsp_poll_ctrl.sv ====
// host-side toggle-bit status poller for an asynchronous parallel flash
`timescale 1ns/1ps
`default_nettype none
module fwsp_poll_ctrl
  import fwsp_pkg::*;
#(
  parameter int STROBE = STROBE_CYC,
  parameter int MAX_POLLS = 65535        // polls before giving up, 0 = unlimited
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // user side
  input wire logic start_in,              // begin a status poll
  input wire logic [ADDR_W-1:0] status_addr_in,  // valid status address
  input wire logic abandon_in,            // leave to do other work
  output logic busy_out,
  output logic done_out,                  // one-cycle result pulse
  output logic [1:0] result_out,
  output logic [DATA_W-1:0] status_out,   // last status byte read
  output logic erase_window_out,          // erase window bit of last read
  output logic sector_toggling_out,       // sector toggle bit changed
  output logic flash_busy_out,            // synchronised busy pin
  // flash pins
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic busy_pin_n_in,
  output logic [ADDR_W-1:0] flash_addr_out,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n_out,
  output logic chip_en_n_out,
  output logic out_en_n_out,
  output logic wr_en_n_out
);
  // refuse poll limits that the sixteen-bit poll counter cannot hold
  if (MAX_POLLS < 0 || MAX_POLLS > 65535) begin : g_bad_polls
    $error("poll limit out of range");
  end

  typedef enum logic [2:0] {
    FWSP_IDLE, FWSP_READ_A, FWSP_READ_B, FWSP_JUDGE, FWSP_RECHECK,
    FWSP_RESET_WR, FWSP_REPORT
  } fwsp_state_t;

  fwsp_state_t st_q, st_d;
  logic [DATA_W-1:0] prev_q, prev_d;      // capture of earlier read
  logic [DATA_W-1:0] cur_q, cur_d;        // capture of latest read
  logic [1:0] res_q, res_d;
  logic done_q, done_d;
  logic after_fail_q, after_fail_d;       // rechecking after fail bit high
  logic stog_q, stog_d;                   // sector toggle bit moved in latest pair
  logic [15:0] polls_q, polls_d;
  logic cyc_start, cyc_write, cyc_done;
  logic [ADDR_W-1:0] cyc_addr;
  logic [DATA_W-1:0] cyc_rdata;
  logic by1_q, by2_q, by3_q, by_q;        // busy pin sampler and filtered level

  // true when the given bit differs between two captures
  function automatic logic bit_moved(input logic [DATA_W-1:0] a,
                                     input logic [DATA_W-1:0] b, input int idx);
    bit_moved = a[idx] ^ b[idx];
  endfunction : bit_moved

  fwsp_bus_cycle #(.STROBE(STROBE)) u_cycle (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .start_in(cyc_start),
    .write_in(cyc_write),
    .addr_in(cyc_addr),
    .wdata_in(RESET_CMD),
    .dq_in(dq_in),
    .done_out(cyc_done),
    .rdata_out(cyc_rdata),
    .addr_out(flash_addr_out),
    .dq_out(dq_out),
    .dq_oe_n_out(dq_oe_n_out),
    .chip_en_n_out(chip_en_n_out),
    .out_en_n_out(out_en_n_out),
    .wr_en_n_out(wr_en_n_out)
  );

  // issue a bus cycle on entry of each reading or writing state
  logic issued_q, issued_d;
  assign cyc_start = (st_q == FWSP_READ_A || st_q == FWSP_READ_B || st_q == FWSP_RESET_WR)
                     && !issued_q;
  assign cyc_write = (st_q == FWSP_RESET_WR);
  // status reads use the user's address so sector and polarity bits mean something
  assign cyc_addr = cyc_write ? ADDR_W'(RESET_ADDR) : status_addr_in;

  // poll sequencer next-state logic
  always_comb begin
    st_d = st_q;
    prev_d = prev_q;
    cur_d = cur_q;
    res_d = res_q;
    done_d = 1'b0;
    after_fail_d = after_fail_q;
    stog_d = stog_q;
    polls_d = polls_q;
    issued_d = issued_q;
    if (cyc_start) issued_d = 1'b1;
    unique case (st_q)
      FWSP_IDLE: begin
        if (start_in) begin
          // every poll begins from the first read again
          st_d = FWSP_READ_A;
          after_fail_d = 1'b0;
          polls_d = 16'h0000;
          issued_d = 1'b0;
        end
      end
      FWSP_READ_A: begin
        if (cyc_done) begin
          prev_d = cyc_rdata;
          st_d = FWSP_READ_B;
          issued_d = 1'b0;
        end
      end
      FWSP_READ_B: begin
        if (cyc_done) begin
          cur_d = cyc_rdata;
          // registered so the sector flag is a flop output like the other data
          stog_d = bit_moved(prev_q, cyc_rdata, BIT_SECTOR_TOGGLE);
          st_d = FWSP_JUDGE;
          issued_d = 1'b0;
        end
      end
      FWSP_JUDGE: begin
        if (!bit_moved(prev_q, cur_q, BIT_RUN_TOGGLE)) begin
          // toggle stopped: finished, next read yields array data
          res_d = RES_PASS;
          st_d = FWSP_REPORT;
        end else if (after_fail_q) begin
          // still toggling after fail bit: failed, restore array reads
          res_d = RES_FAIL;
          st_d = FWSP_RESET_WR;
        end else begin
          st_d = FWSP_RECHECK;
        end
      end
      FWSP_RECHECK: begin
        polls_d = polls_q + 16'h0001;
        if (cur_q[BIT_TIMEOUT_FAIL]) begin
          // toggle may have stopped just as the fail bit rose
          after_fail_d = 1'b1;
          st_d = FWSP_READ_A;
        end else if (abandon_in ||
                     (MAX_POLLS != 0 && polls_q >= 16'(MAX_POLLS))) begin
          res_d = RES_RUN;
          st_d = FWSP_REPORT;
        end else begin
          st_d = FWSP_READ_A;
        end
      end
      FWSP_RESET_WR: begin
        if (cyc_done) begin
          st_d = FWSP_REPORT;
          issued_d = 1'b0;
        end
      end
      FWSP_REPORT: begin
        done_d = 1'b1;
        st_d = FWSP_IDLE;
      end
      default: st_d = FWSP_IDLE;
    endcase
  end

  // poll sequencer registers and busy pin sampler
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= FWSP_IDLE;
      prev_q <= '0;
      cur_q <= '0;
      res_q <= 2'h0;
      done_q <= 1'b0;
      after_fail_q <= 1'b0;
      stog_q <= 1'b0;
      polls_q <= 16'h0000;
      issued_q <= 1'b0;
      by1_q <= 1'b1;
      by2_q <= 1'b1;
      by3_q <= 1'b1;
      by_q <= 1'b1;
    end else if (ce_in) begin
      st_q <= st_d;
      prev_q <= prev_d;
      cur_q <= cur_d;
      res_q <= res_d;
      done_q <= done_d;
      after_fail_q <= after_fail_d;
      stog_q <= stog_d;
      polls_q <= polls_d;
      issued_q <= issued_d;
      by1_q <= busy_pin_n_in;
      by2_q <= by1_q;
      by3_q <= by2_q;
      // level changes only when stages two and three agree
      if (by2_q == by3_q) by_q <= by3_q;
    end
  end

  assign busy_out = (st_q != FWSP_IDLE);
  assign done_out = done_q;
  assign result_out = res_q;
  assign status_out = cur_q;
  // window bit of latest read; user checks it around each sector erase
  // always reported, so the user need not rely on short command spacing
  assign erase_window_out = cur_q[BIT_ERASE_WINDOW];
  assign sector_toggling_out = stog_q;
  // pin low means device busy
  assign flash_busy_out = !by_q;
endmodule : fwsp_poll_ctrl
`default_nettype wire

// ==== fwsp_poll_ctrl_assertions.sv ====
// bound checker for the flash status poller
`timescale 1ns/1ps
`default_nettype none
module fwsp_poll_ctrl_assertions
  import fwsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [1:0] result_out,
  input wire logic [DATA_W-1:0] status_out,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic [ADDR_W-1:0] status_addr_in,
  input wire logic [ADDR_W-1:0] flash_addr_out,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe_n_out,
  input wire logic chip_en_n_out,
  input wire logic out_en_n_out,
  input wire logic wr_en_n_out
);
  logic [7:0] rd_q, prev_q, cur_q; // pin byte, last two reads
  logic [3:0] n_q; // reads this poll
  logic oe_q, wr_q; // strobe delayed, reset written
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_read;
    !chip_en_n_out && !out_en_n_out;
  endsequence
  // latch inside the strobe: the device lets go of the bus after it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {rd_q, prev_q, cur_q, n_q, wr_q} <= '0;
      oe_q <= 1'b1;
    end else begin
      oe_q <= out_en_n_out;
      if (!chip_en_n_out && !out_en_n_out) rd_q <= dq_in;
      if (out_en_n_out && !oe_q) begin
        prev_q <= cur_q;
        cur_q <= rd_q;
        if (n_q != 4'hF) n_q <= n_q + 4'h1; // saturate on long polls
      end
      if (!wr_en_n_out) wr_q <= 1'b1;
      if (start_in && !busy_out) begin
        n_q <= 4'h0;
        wr_q <= 1'b0;
      end
    end
  end
  a_reset_cmd: assert property (
    !wr_en_n_out |-> !chip_en_n_out && dq_out == RESET_CMD
    && flash_addr_out == ADDR_W'(RESET_ADDR)) else $error("bad reset command");
  a_fail_wrote: assert property (
    done_out && result_out == RES_FAIL |-> wr_q) else $error("fail, no reset");
  a_pass_twice: assert property (
    done_out && result_out == RES_PASS |-> n_q >= 4'h2 && !wr_q) else $error("early pass");
  a_pass_equal: assert property (
    done_out && result_out == RES_PASS |-> prev_q[6] == cur_q[6]) else $error("pass on toggle");
  a_write_cause: assert property (
    $fell(wr_en_n_out) |-> n_q >= 4'h4 && cur_q[5] && prev_q[6] != cur_q[6])
    else $error("reset without recheck");
  a_status_last: assert property (
    done_out |-> status_out == cur_q) else $error("status not last read");
  a_read_addr: assert property (
    s_read |-> flash_addr_out == status_addr_in) else $error("read at wrong address");
  a_start_read: assert property (
    start_in && !busy_out |-> ##[1:3] s_read) else $error("no opening read");
  a_bus_drive: assert property (
    dq_oe_n_out == (chip_en_n_out || wr_en_n_out)) else $error("bus driven outside write");
endmodule : fwsp_poll_ctrl_assertions
bind fwsp_poll_ctrl fwsp_poll_ctrl_assertions u_chk (.clk_in, .arst_n_in, .start_in,
  .busy_out, .done_out, .result_out, .status_out, .dq_in, .status_addr_in,
  .flash_addr_out, .dq_out, .dq_oe_n_out, .chip_en_n_out, .out_en_n_out, .wr_en_n_out);
`default_nettype wire

// ==== fwsp_flash_model.sv ====
// behavioural flash device answering status reads and reset
`timescale 1ns/1ps
`default_nettype none
module fwsp_flash_model
  import fwsp_pkg::*;
(
  input wire logic go_in, // starts an embedded operation
  input wire logic [7:0] len_in, // reads until done, 0 = 256 reads
  input wire logic [7:0] fail_in, // read that trips fail, 0 = never
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] host_dq_in,
  input wire logic chip_en_n_in,
  input wire logic out_en_n_in,
  input wire logic wr_en_n_in,
  output logic [DATA_W-1:0] dq_out,
  output logic busy_pin_n_out
);
  logic run_q = 1'b0; // operation running
  logic fail_q = 1'b0;
  logic tog_q = 1'b0;
  logic stog_q = 1'b0;
  logic [7:0] n_q = 8'h00; // reads since start
  logic [7:0] last_q = 8'h00;
  wire logic rd_n = chip_en_n_in | out_en_n_in;
  wire logic wr_n = chip_en_n_in | wr_en_n_in;
  // window opens after two reads, standing in for the selection timeout
  // only sector erase is modelled, so the window bit always runs its timeout
  wire logic [7:0] stat = {1'b0, tog_q, fail_q, 1'b0, n_q > 8'h01, stog_q, 2'b00};
  // a released bus shows the inverse of the last byte, never a stale copy
  assign dq_out = rd_n ? ~last_q : run_q ? stat : 8'h5A;
  assign busy_pin_n_out = !run_q;
  always @(posedge go_in) begin
    run_q = 1'b1;
    fail_q = 1'b0;
    n_q = 8'h00;
  end
  // status bits move once per completed read
  always @(posedge rd_n) begin
    last_q = run_q ? stat : 8'h5A;
    if (run_q) begin
      tog_q = !tog_q;
      stog_q = stog_q ^ (addr_in[21:16] == 6'h3F);
      n_q = n_q + 8'h01;
      // the trip also stands for a zero-to-one program attempt
      if (fail_in != 8'h00 && n_q >= fail_in) fail_q = 1'b1;
      else if (n_q == len_in) run_q = 1'b0;
    end
  end
  // once erase has begun only a failed operation takes the reset command
  always @(posedge wr_n) begin
    if (host_dq_in == RESET_CMD && (!run_q || fail_q || n_q < 8'h02)) begin
      run_q = 1'b0;
      fail_q = 1'b0;
    end
  end
endmodule : fwsp_flash_model
`default_nettype wire

// ==== fwsp_poll_ctrl_tb_top.sv ====
// self-checking bench for the status poller
`timescale 1ns/1ps
`default_nettype none
module fwsp_poll_ctrl_tb_top
  import fwsp_pkg::*;
;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic start_in = 1'b0;
  logic abandon_in = 1'b0;
  logic go = 1'b0; // device operation start
  logic ce = 1'b1; // clock enable, dropped now and then
  logic [ADDR_W-1:0] status_addr_in = '0;
  logic [7:0] rl = 8'h00;
  logic [7:0] fa = 8'h00;
  logic [DATA_W-1:0] dq_in, dq_out, status_out;
  logic [ADDR_W-1:0] flash_addr_out;
  logic [1:0] result_out;
  logic busy_out, done_out, erase_window_out, sector_toggling_out, flash_busy_out;
  logic busy_pin_n_in, dq_oe_n_out, chip_en_n_out, out_en_n_out, wr_en_n_out;
  logic [31:0] lfsr = 32'hD86C;
  int n_mismatch = 0;
  int comparisons = 0;
  int k;
  always #20 clk_in = ~clk_in;
  // small poll limit keeps endless operations short
  fwsp_poll_ctrl #(.MAX_POLLS(4)) uut (.clk_in, .arst_n_in, .ce_in(ce), .start_in,
    .status_addr_in, .abandon_in, .busy_out, .done_out, .result_out, .status_out,
    .erase_window_out, .sector_toggling_out, .flash_busy_out, .dq_in, .busy_pin_n_in,
    .flash_addr_out, .dq_out, .dq_oe_n_out, .chip_en_n_out, .out_en_n_out, .wr_en_n_out);
  fwsp_flash_model dev (.go_in(go), .len_in(rl), .fail_in(fa), .addr_in(flash_addr_out),
    .host_dq_in(dq_out), .chip_en_n_in(chip_en_n_out), .out_en_n_in(out_en_n_out),
    .wr_en_n_in(wr_en_n_out), .dq_out(dq_in), .busy_pin_n_out(busy_pin_n_in));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // outcome of a poll from the device behaviour we set up
  function automatic logic [1:0] exp_res(input logic g, input logic [7:0] l, f);
    if (g && f != 8'h00) return RES_FAIL;
    if (g && l == 8'h00) return RES_RUN;
    return RES_PASS;
  endfunction : exp_res
  // start the device except in the idle case, then one poll, waiting a bounded time for done
  task automatic poll();
    int t;
    @(negedge clk_in);
    go = (k % 4 != 2);
    @(negedge clk_in);
    go = 1'b0;
    start_in = 1'b1;
    @(negedge clk_in);
    start_in = 1'b0;
    for (t = 0; t < 3000 && done_out !== 1'b1; t++) begin
      ce = (t % 7 != 3); // freeze the poller one cycle in seven
      @(negedge clk_in);
    end
    ce = 1'b1;
    check("done", 8'(done_out), 8'h01);
  endtask : poll
  initial begin
    repeat (20) @(negedge clk_in);
    check("idle pins", 8'({chip_en_n_out, out_en_n_out, wr_en_n_out, dq_oe_n_out,
      busy_out, done_out}), 8'h3C);
    arst_n_in = 1'b1;
    // order pass, fail, idle device, endless: each leaves the device as the next needs
    for (k = 0; k < 12; k++) begin
      lfsr = nxt(lfsr);
      rl = (k % 4 == 0) ? 8'(lfsr[1:0]) + 8'h01 : 8'h00;
      fa = (k % 4 == 1) ? 8'(lfsr[3:2] % 3) + 8'h01 : 8'h00;
      abandon_in = (k % 4 == 3) & lfsr[4];
      status_addr_in = {lfsr[5] ? 6'h3F : 6'h01, lfsr[21:6]};
      poll();
      check("result", 8'(result_out), 8'(exp_res(k % 4 != 2, rl, fa)));
      if (k % 4 == 0 || k % 4 == 2) check("array", status_out, 8'h5A);
      if (k % 4 == 2) check("flash idle", 8'(flash_busy_out), 8'h00);
      if (k % 4 == 1) begin
        check("fail bit", 8'(status_out[5]), 8'h01);
        check("pin free", 8'(busy_pin_n_in), 8'h01);
      end
      if (k % 4 == 3) begin
        check("sector", 8'(sector_toggling_out), 8'(lfsr[5]));
        check("window", 8'(erase_window_out), 8'(!abandon_in));
        check("flash busy", 8'(flash_busy_out), 8'h01);
      end
      abandon_in = 1'b0;
    end
    report_and_stop();
  end
  // a dozen polls take under a thousand cycles; the 50000-cycle limit is ample
  initial begin
    #2000000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : fwsp_poll_ctrl_tb_top
`default_nettype wire
